// ---- sls_pkg.sv ----
// Purpose: Shared constants and types for the scan list sequencer
// Assumes: 100 MHz ref_clk
// Notes:   Register offsets are byte addresses on the plain port
package sls_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int     CLK_HZ        = 100_000_000;
    localparam int     MAX_RATE_SPS  = 500_000;
    localparam int     MIN_RATE_CSPS = 75;  // 0.75 S/s in hundredths
    localparam int     MIN_PERIOD    =
        (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
    localparam longint MAX_PERIOD_L  =
        (longint'(CLK_HZ) * 100) / MIN_RATE_CSPS;

    // ------------------------------------------------------------
    // Channel list
    // ------------------------------------------------------------
    localparam int LIST_AW   = 10;      // 1,024 entries
    localparam int ENTRY_W   = 10;
    localparam int CODE_LSB  = 0;
    localparam int CODE_W    = 6;
    localparam int GAIN_LSB  = 6;
    localparam int GAIN_W    = 2;
    localparam int INH_BIT   = 8;
    localparam int DYN_BIT   = 9;
    localparam logic [CODE_W-1:0] DIO_SMALL = 6'h10;
    localparam logic [CODE_W-1:0] DIO_LARGE = 6'h20;
    localparam logic [CODE_W-1:0] CTR_FIRST = 6'h01;
    localparam logic [CODE_W-1:0] CTR_LAST  = 6'h0A;
    localparam int N_CTR     = 5;
    localparam int CNT_W     = 32;
    localparam int SMP_W     = 16;
    localparam int CHAN_W    = 5;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LAST   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_WPTR   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_ENTRY  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
    localparam int CTRL_W    = 4;
    localparam int C_RUN     = 0;
    localparam int C_EXT     = 1;
    localparam int C_DYN     = 2;
    localparam int C_LARGE   = 3;
    localparam int ST_BUSY   = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
    localparam logic [DATA_W-1:0] PERIOD_RST = DATA_W'(MIN_PERIOD);

    typedef enum logic [1:0] {
        S_WAIT  = 2'b00,
        S_ISSUE = 2'b01,
        S_CONV  = 2'b10
    } sls_state_e;
endpackage

// ---- sls_list_mem.sv ----
// Purpose: Channel list storage, one write port, registered read
// Assumes: Contents undefined until written
// Notes:   Read data lag the address by one clock
`timescale 1ns/1ps
module sls_list_mem
    import sls_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               we,
    input  wire logic [LIST_AW-1:0] waddr,
    input  wire logic [ENTRY_W-1:0] wdata,
    input  wire logic [LIST_AW-1:0] raddr,
    output logic      [ENTRY_W-1:0] rdata
);
    logic [ENTRY_W-1:0] mem [2**LIST_AW];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // sls_list_mem

// ---- sls_pacer.sv ----
// Purpose: Sample clock pacing, internal divider or external edge
// Assumes: ext_clk_pin is asynchronous to ref_clk
// Notes:   Internal period clamped to the legal rate range
`timescale 1ns/1ps
module sls_pacer
    import sls_pkg::*;
#(
    parameter int MAX_PERIOD = int'(MAX_PERIOD_L)
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              run,
    input  wire logic              ext_sel,
    input  wire logic [DATA_W-1:0] period,
    input  wire logic              ext_clk_pin,
    output logic                   tick
);
    typedef struct packed {
        logic              s1;
        logic              s2;
        logic              s3;
        logic [DATA_W-1:0] cnt;
        logic [DATA_W-1:0] gap;
        logic              tick;
    } sls_pacer_s;

    sls_pacer_s r;
    sls_pacer_s next_r;
    logic [DATA_W-1:0] lim;

    always_comb begin
        next_r      = r;
        next_r.s1   = ext_clk_pin;
        next_r.s2   = r.s1;
        next_r.s3   = r.s2;
        next_r.tick = 1'b0;
        if (period < DATA_W'(MIN_PERIOD)) begin
            lim = DATA_W'(MIN_PERIOD);
        end else if (period > DATA_W'(MAX_PERIOD)) begin
            lim = DATA_W'(MAX_PERIOD);
        end else begin
            lim = period;
        end
        if (!run || ext_sel) begin
            next_r.cnt  = '0;
            // Falling edge, no division in external mode
            next_r.tick = run && ext_sel && r.s3 && !r.s2;
        end else if (r.cnt >= lim - 32'h0000_0001) begin
            next_r.cnt  = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt  = r.cnt + 32'h0000_0001;
        end
        if (r.tick) begin
            next_r.gap = '0;
        end else if (r.gap != '1) begin
            next_r.gap = r.gap + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r     <= '0;
            r.gap <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_int_spacing;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.tick && !$past(ext_sel)) |-> (r.gap >= MIN_PERIOD - 1);
    endproperty
    a_int_spacing: assert property (p_int_spacing)
        else $error("internal ticks closer than the rate limit");

    property p_ext_edge;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.tick && $past(ext_sel)) |-> ($past(r.s3) && !$past(r.s2));
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external tick without a falling edge");
endmodule // sls_pacer

// ---- sls_sequencer.sv ----
// Purpose: Channel list sequencer: analog, digital port, counters
// Assumes: Converter and counters run on ref_clk; pins are async
// Notes:   Dynamic output line has power-up value only, no reset
//
// Function
// - Counter read as low word then high word
// - Low-half sample latches whole 32-bit count
// - Counter codes follow digital port code
// - Counter codes allowed anywhere, any count
// - Counter entries sequenced like analog entries
// - Aggregate rate capped at 500 kS/s under internal pacing; external ticks have no cap
// - Dynamic line powers up low, reset-proof
// - Entry bit drives dynamic line when enabled
// - Per-entry gain code for analog entries
// - Code 16 or 32 reads digital port
// - Internal pacing 0.75 S/s to 500 kS/s
// - External pacing on falling clock edge
// - Software selects internal or external pacing
// - Pacing clock also paces port, counters
// - List of 1,024 entries, in order
// - Inhibited entries produce no sample word
// - Port sample holds all 16 lines
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module sls_sequencer
    import sls_pkg::*;
#(
    parameter int MAX_PERIOD = int'(MAX_PERIOD_L)
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic [ADDR_W-1:0]           reg_addr,
    input  wire logic [DATA_W-1:0]           reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [DATA_W-1:0]           reg_rdata,
    input  wire logic                        ext_clk_pin,
    input  wire logic [SMP_W-1:0]            din_pin,
    input  wire logic [N_CTR-1:0][CNT_W-1:0] cnt_value,
    output logic                             conv_start,
    output logic      [CHAN_W-1:0]           conv_chan,
    output logic      [GAIN_W-1:0]           conv_gain,
    input  wire logic                        conv_done,
    input  wire logic [SMP_W-1:0]            conv_data,
    output logic                             smp_valid,
    output logic      [SMP_W-1:0]            smp_data,
    output logic                             dyn_out
);
    typedef struct packed {
        sls_state_e                  st;
        logic [CTRL_W-1:0]           ctrl;
        logic [DATA_W-1:0]           period;
        logic [LIST_AW-1:0]          last;
        logic [LIST_AW-1:0]          wptr;
        logic [LIST_AW-1:0]          idx;
        logic [DATA_W-1:0]           rdata;
        logic [SMP_W-1:0]            din1;
        logic [SMP_W-1:0]            din2;
        logic [N_CTR-1:0][CNT_W-1:0] hold;
        logic                        valid;
        logic [SMP_W-1:0]            data;
    } sls_main_s;

    sls_main_s          r;
    sls_main_s          next_r;
    logic [ENTRY_W-1:0] entry;
    logic               tick;
    logic               list_we;
    logic [CODE_W-1:0]  code;
    logic [CODE_W-1:0]  dio_code;
    logic [CODE_W-1:0]  off;
    logic               is_an;
    logic               is_dio;
    logic               is_ctr;
    logic               is_lo;
    logic               is_hi;
    logic               inh;
    logic [2:0]         ctr_k;
    logic [CNT_W-1:0]   cnt_sel;
    logic [CNT_W-1:0]   hold_sel;
    logic [SMP_W-1:0]   value;
    logic [LIST_AW-1:0] idx_step;
    // Power-up value only: a module reset must not disturb it
    logic               dyn_line = 1'b0;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    assign list_we = reg_wr && (reg_addr == REG_ENTRY);

    sls_list_mem u_mem (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .we      (list_we),
        .waddr   (r.wptr),
        .wdata   (reg_wdata[ENTRY_W-1:0]),
        .raddr   (r.idx),
        .rdata   (entry)
    );

    sls_pacer #(
        .MAX_PERIOD (MAX_PERIOD)
    ) u_pacer (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .run         (r.ctrl[C_RUN]),
        .ext_sel     (r.ctrl[C_EXT]),
        .period      (r.period),
        .ext_clk_pin (ext_clk_pin),
        .tick        (tick)
    );

    // ------------------------------------------------------------
    // Entry decode
    // ------------------------------------------------------------
    assign code     = entry[CODE_LSB +: CODE_W];
    assign inh      = entry[INH_BIT];
    assign dio_code = r.ctrl[C_LARGE] ? DIO_LARGE : DIO_SMALL;
    assign off      = code - dio_code;
    assign is_an    = code < dio_code;
    assign is_dio   = code == dio_code;
    assign is_ctr   = (off >= CTR_FIRST) && (off <= CTR_LAST);
    assign is_lo    = is_ctr && off[0];
    assign is_hi    = is_ctr && !off[0];
    assign ctr_k    = is_ctr ? 3'((off - CTR_FIRST) >> 1) : 3'h0;
    assign cnt_sel  = cnt_value[ctr_k];
    assign hold_sel = r.hold[ctr_k];
    assign idx_step = (r.idx == r.last) ? '0 : r.idx + 10'h001;

    always_comb begin
        if (is_lo) begin
            value = cnt_sel[SMP_W-1:0];
        end else if (is_hi) begin
            value = hold_sel[CNT_W-1:SMP_W];
        end else if (is_dio) begin
            value = r.din2;
        end else begin
            value = '0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        next_r       = r;
        next_r.din1  = din_pin;
        next_r.din2  = r.din1;
        next_r.valid = 1'b0;
        next_r.rdata = '0;
        unique case (r.st)
            S_WAIT: begin
                // Port and counters paced the same as analog
                if (tick) begin
                    next_r.st = S_ISSUE;
                end
            end
            S_ISSUE: begin
                if (is_an) begin
                    next_r.st = S_CONV;
                end else begin
                    if (is_lo) begin
                        next_r.hold[ctr_k] = cnt_sel;
                    end
                    next_r.valid = !inh;
                    next_r.data  = value;
                    next_r.idx   = idx_step;
                    next_r.st    = S_WAIT;
                end
            end
            S_CONV: begin
                if (conv_done) begin
                    next_r.valid = !inh;
                    next_r.data  = conv_data;
                    next_r.idx   = idx_step;
                    next_r.st    = S_WAIT;
                end
            end
        endcase
        if (!r.ctrl[C_RUN]) begin
            next_r.st  = S_WAIT;
            next_r.idx = '0;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL:   next_r.ctrl   = reg_wdata[CTRL_W-1:0];
                REG_PERIOD: next_r.period = reg_wdata;
                REG_LAST:   next_r.last   = reg_wdata[LIST_AW-1:0];
                REG_WPTR:   next_r.wptr   = reg_wdata[LIST_AW-1:0];
                REG_ENTRY:  next_r.wptr   = r.wptr + 10'h001;
                default:    next_r.ctrl   = r.ctrl;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:   next_r.rdata = DATA_W'(r.ctrl);
                REG_PERIOD: next_r.rdata = r.period;
                REG_LAST:   next_r.rdata = DATA_W'(r.last);
                REG_WPTR:   next_r.rdata = DATA_W'(r.wptr);
                REG_STATUS: begin
                    next_r.rdata          = DATA_W'(r.idx);
                    next_r.rdata[ST_BUSY] = r.st != S_WAIT;
                end
                default:    next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r        <= '0;
            r.st     <= S_WAIT;
            r.ctrl   <= CTRL_RST;
            r.period <= PERIOD_RST;
        end else begin
            r <= next_r;
        end
    end

    // No reset term: level survives a module reset
    always_ff @(posedge ref_clk) begin
        if (r.st == S_ISSUE && r.ctrl[C_DYN]) begin
            dyn_line <= entry[DYN_BIT];
        end
    end

    assign conv_start = (r.st == S_ISSUE) && is_an;
    assign conv_chan  = code[CHAN_W-1:0];
    assign conv_gain  = entry[GAIN_LSB +: GAIN_W];
    assign smp_valid  = r.valid;
    assign smp_data   = r.data;
    assign reg_rdata  = r.rdata;
    assign dyn_out    = dyn_line;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_lo_word;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && is_lo && !inh && r.ctrl[C_RUN]) |=>
            (smp_valid && smp_data == $past(cnt_sel[SMP_W-1:0]));
    endproperty
    a_lo_word: assert property (p_lo_word)
        else $error("low counter word not returned");

    property p_latch;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && is_lo && r.ctrl[C_RUN]) |=>
            (r.hold[$past(ctr_k)] == $past(cnt_sel));
    endproperty
    a_latch: assert property (p_latch)
        else $error("counter not latched on low word");

    property p_hi_word;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && is_hi && !inh && r.ctrl[C_RUN]) |=>
            (smp_valid && smp_data == $past(hold_sel[CNT_W-1:SMP_W]));
    endproperty
    a_hi_word: assert property (p_hi_word)
        else $error("high word not taken from latch");

    property p_dio;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && is_dio && !inh && r.ctrl[C_RUN]) |=>
            (smp_valid && smp_data == $past(r.din2));
    endproperty
    a_dio: assert property (p_dio)
        else $error("digital port sample mismatch");

    property p_inhibit;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && inh && !is_an) |=> !smp_valid;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibited entry produced a sample");

    property p_conv;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && is_an && r.ctrl[C_RUN]) |->
            conv_start ##1 (r.st == S_CONV);
    endproperty
    a_conv: assert property (p_conv)
        else $error("analog entry did not start conversion");

    property p_dyn;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.st == S_ISSUE && r.ctrl[C_DYN]) |=>
            (dyn_out == $past(entry[DYN_BIT]));
    endproperty
    a_dyn: assert property (p_dyn)
        else $error("dynamic line not driven from entry");

    property p_dyn_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        !r.ctrl[C_DYN] |=> $stable(dyn_out);
    endproperty
    a_dyn_hold: assert property (p_dyn_hold)
        else $error("dynamic line moved while disabled");

    property p_order;
        @(posedge ref_clk) disable iff (!rst_b)
        (next_r.valid && r.ctrl[C_RUN]) |=>
            (r.idx == (($past(r.idx) == $past(r.last)) ? 10'h000
                       : $past(r.idx) + 10'h001));
    endproperty
    a_order: assert property (p_order)
        else $error("list index did not advance in order");
endmodule // sls_sequencer

// ---- sls_conv_model.sv ----
// Purpose: Converter model facing the sequencer's conversion port
// Assumes: One conversion outstanding at a time
// Notes:   Delay depends on channel, so answers come prompt or slow
`timescale 1ns/1ps
module sls_conv_model
    import sls_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              conv_start,
    input  wire logic [CHAN_W-1:0] conv_chan,
    input  wire logic [GAIN_W-1:0] conv_gain,
    output logic                   conv_done,
    output logic      [SMP_W-1:0]  conv_data
);
    int               left = 0;
    logic [SMP_W-1:0] res  = '0;
    initial conv_done = 1'b0;
    initial conv_data = '0;
    // ------------------------------------------------------------
    // Conversion
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        // Data not valid between answers: keep it moving
        conv_data <= ~conv_data;
        if (conv_start === 1'b1) begin
            left = 1 + 7 * conv_chan[1:0];
            res  = {3'h0, conv_chan, 6'h00, conv_gain};
        end else if (left > 0) begin
            left = left - 1;
            if (left == 0) begin
                conv_done <= 1'b1;
                conv_data <= res;
            end
        end
    end
endmodule // sls_conv_model

// ---- scan_list_entry_sequencer_tb.sv ----
// Purpose: Self-checking bench for the scan list sequencer
// Assumes: Converter model as far side; counters driven by bench
// Notes:   Counter high word = low word + k + 0x1000 when latched
`timescale 1ns/1ps
module scan_list_entry_sequencer_tb
    import sls_pkg::*;
;
    logic                        ref_clk = 0, rst_b = 0, ext_clk_pin = 1;
    logic                        reg_wr = 0, reg_rd = 0, exp_dyn = 0;
    logic [ADDR_W-1:0]           reg_addr = '0;
    logic [DATA_W-1:0]           reg_wdata = '0, reg_rdata, rd;
    logic [SMP_W-1:0]            din_pin = '0, conv_data, smp_data;
    logic [SMP_W-1:0]            lo [N_CTR];
    logic [N_CTR-1:0][CNT_W-1:0] cnt_value;
    logic [CHAN_W-1:0]           conv_chan;
    logic [GAIN_W-1:0]           conv_gain;
    logic                        conv_start, conv_done, smp_valid, dyn_out;
    logic [ENTRY_W-1:0]          ent [16];
    logic [5:0]                  base;
    logic [ADDR_W-1:0]           ra [7] = '{REG_CTRL, REG_PERIOD,
        REG_LAST, REG_WPTR, REG_ENTRY, REG_STATUS, 8'h40};
    logic [DATA_W-1:0]           rv [7] = '{0, PERIOD_RST, 0, 0, 0, 0, 0};
    int failures = 0, check_count = 0, seed = 49313, cyc = 0;
    int n_ent, p, got, last_t, prev_na, gap, dyn_en, int_mode;

    sls_sequencer #(.MAX_PERIOD(1000)) dut (.ref_clk, .rst_b, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_clk_pin, .din_pin,
        .cnt_value, .conv_start, .conv_chan, .conv_gain, .conv_done,
        .conv_data, .smp_valid, .smp_data, .dyn_out);
    sls_conv_model cm (.ref_clk, .conv_start, .conv_chan, .conv_gain,
        .conv_done, .conv_data);

    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    always_comb for (int k = 0; k < N_CTR; k++)
        cnt_value[k] = {16'(cyc) + 16'(k) + 16'h1000, 16'(cyc)};

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] e, logic [31:0] a);
        check_count++;
        if (a !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, a);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic reg_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [15:0] word_of(logic [ENTRY_W-1:0] e);
        logic [5:0] off;
        off = e[5:0] - base;
        if (e[5:0] < base) return {3'h0, e[4:0], 6'h00, e[7:6]};
        if (off == 0) return din_pin;
        if (off > 10) return '0;
        return lo[off/2-1] + 16'(off/2-1) + 16'h1000;
    endfunction

    // Analog codes random; port and counters get gain code 0
    task automatic build(int big);
        logic [5:0] c;
        base = big ? 6'h20 : 6'h10;
        for (int i = 0; i < 16; i++) begin
            c = (i > 1 && i < 12) ? base + 6'(i - 1) : (i == 1) ? base :
                (i == 13) ? base + 6'h06 : (i == 14) ? base + 6'h0b :
                6'($random(seed)) & (base - 6'h01);
            ent[i] = {(i == 15) | 1'($random(seed)), i == 12,
                (c < base) ? 2'($random(seed)) : 2'b00, c};
        end
    endtask

    task automatic run_list(int n, logic [3:0] ctrl, int per, int g,
                            int words);
        int t;
        reg_write(REG_WPTR, 0);
        for (int i = 0; i < n; i++)
            reg_write(REG_ENTRY, 32'(ent[i]));
        reg_write(REG_LAST, n - 1);
        reg_write(REG_PERIOD, per);
        n_ent = n;
        p = 0;
        got = 0;
        prev_na = 0;
        gap = g;
        dyn_en = ctrl[C_DYN];
        int_mode = !ctrl[C_EXT];
        din_pin <= 16'($random(seed));
        reg_write(REG_CTRL, ctrl);
        for (t = 0; t < 20000 && got < words; t++) begin
            if (ctrl[C_EXT])
                ext_clk_pin <= t[3];
            @(posedge ref_clk);
        end
        repeat (40) @(posedge ref_clk);
        check("count", words, got);
        reg_read(REG_STATUS, rd);
        // Next tick is far off, so the sequencer sits idle here
        check("busy", 0, rd[ST_BUSY]);
        reg_write(REG_CTRL, 0);
        reg_read(REG_STATUS, rd);
        check("stopped", 0, rd);
    endtask

    // ------------------------------------------------------------
    // Sample monitor, walks the list as the host would
    // ------------------------------------------------------------
    always @(posedge ref_clk) if (smp_valid === 1'b1) begin : mon
        logic [5:0] off;
        int         na;
        while (ent[p][INH_BIT] === 1'b1) begin
            p = (p + 1) % n_ent;
            prev_na = 0;
        end
        off = ent[p][5:0] - base;
        na = ent[p][5:0] >= base;
        if (na && off[0] && off < 11) begin
            lo[off/2] = smp_data;
            // Live count of the issue cycle, one before the valid cycle
            check("low", 16'(cyc - 1), smp_data);
        end else begin
            check("sample", word_of(ent[p]), smp_data);
        end
        if (na && prev_na && int_mode)
            check("gap", gap, cyc - last_t);
        prev_na = na;
        last_t = cyc;
        if (dyn_en)
            exp_dyn = ent[p][DYN_BIT];
        check("dyn", exp_dyn, dyn_out);
        p = (p + 1) % n_ent;
        got++;
    end

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        check("dyn", 1'b0, dyn_out);
        rst_b <= 1'b1;
        foreach (ra[i]) begin
            reg_read(ra[i], rd);
            check("reset reg", rv[i], rd);
        end
        build(0);
        run_list(16, 4'b0101, 100, MIN_PERIOD, 30);
        build(1);
        run_list(16, 4'b1101, 300, 300, 30);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("dyn", 1'b1, dyn_out);
        rst_b <= 1'b1;
        base = 6'h10;
        // Inhibited port entry: a non-analog entry must drop its word
        ent[0] = 10'h110;
        ent[1] = 10'h013;
        ent[2] = 10'h014;
        run_list(3, 4'b0011, 200, 0, 6);
        end_of_test();
    end

    initial begin
        #500_000;
        failures++;
        end_of_test();
    end
endmodule // scan_list_entry_sequencer_tb
